// ### core/regfile_pkg.sv
package regfile_pkg;

    localparam int unsigned DATA_W         = 8;
    localparam int unsigned OFFSET_W       = 7;
    localparam logic [6:0]  OFFSET_TOP     = 7'h7f;
    localparam logic [6:0]  OFFSET_INTCTL  = 7'h0b;
    localparam logic [6:0]  GPR_FIRST      = 7'h0c;
    localparam int unsigned SFR_COUNT      = 12;
    localparam int unsigned GPR_DEPTH      = 116;
    localparam int unsigned STATUS_BANK_BIT = 5;

    localparam int unsigned BIT_GLOBAL_EN   = 7;
    localparam int unsigned BIT_NVM_EN      = 6;
    localparam int unsigned BIT_TIMER_EN    = 5;
    localparam int unsigned BIT_EXT_EN      = 4;
    localparam int unsigned BIT_PORT_EN     = 3;
    localparam int unsigned BIT_TIMER_FLAG  = 2;
    localparam int unsigned BIT_EXT_FLAG    = 1;
    localparam int unsigned BIT_PORT_FLAG   = 0;

    localparam logic [7:0]  INTCTL_RESET    = 8'h00;
    localparam logic [7:0]  READ_DATA_RESET = 8'h00;

    // Bank page bit does not take part: general RAM is shared by both banks
    function automatic logic [6:0] gpr_index(input logic [6:0] offset);
        gpr_index = offset - GPR_FIRST;
    endfunction

    function automatic logic is_gpr(input logic [6:0] offset);
        is_gpr = (offset >= GPR_FIRST);
    endfunction

endpackage

// ### core/general_ram.sv
`timescale 1ns/1ns
`default_nettype none
module general_ram
    import regfile_pkg::*;
(
    // Clock
    input  wire logic                clk_sys,
    // Write port
    input  wire logic                write_en,
    input  wire logic [6:0]          write_index,
    input  wire logic [DATA_W-1:0]   write_data,
    // Read port
    input  wire logic [6:0]          read_index,
    output logic      [DATA_W-1:0]   read_data
);

    logic [DATA_W-1:0] mem      [GPR_DEPTH];
    logic [DATA_W-1:0] next_mem [GPR_DEPTH];

    always_comb begin
        next_mem = mem;
        if (write_en && (32'(write_index) < GPR_DEPTH)) begin
            next_mem[write_index] = write_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        mem <= next_mem;
    end

    assign read_data = (32'(read_index) < GPR_DEPTH) ? mem[read_index] : '0;

endmodule // general_ram
`default_nettype wire

// ### core/banked_register_file_intctl.sv
// Overview of operation
// - Two banks; status bank page bit 0 picks bank 0, 1 picks bank 1.
// - Each bank spans offsets 00h to 7Fh, 128 byte locations.
// - Lowest twelve offsets are special-function area; the rest are general RAM.
// - Each general RAM byte holds 8 bits, direct or indirect access.
// - General RAM in bank 1 aliases bank 0; 0Ch and 8Ch same byte.
// - Any location is reached by direct address or by file-select pointer.
// - Indirect access takes its bank from the current bank page bit.
// - Bytes move from working register to interrupt control or general RAM and back; other offsets read 0.
// - Interrupt control sits at 0Bh and 8Bh, one register.
// - Interrupt control is read/write and holds all source enables.
// - Flags set on their event regardless of own or global enable.
// - Bit 7 global enable passes unmasked sources; 0 blocks all.
// - Bit 6 enables the nonvolatile write-complete interrupt.
// - Write completion clears write-start and sets done flag; software clears flag.
`timescale 1ns/1ns
`default_nettype none
module banked_register_file_intctl
    import regfile_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    // Core access
    input  wire logic                access_valid,
    input  wire logic                access_write,
    input  wire logic                access_indirect,
    input  wire logic [6:0]          direct_address,
    input  wire logic [7:0]          file_select_pointer,
    input  wire logic                bank_page_bit,
    input  wire logic [DATA_W-1:0]   write_data,
    output logic      [DATA_W-1:0]   read_data,
    output logic                     read_valid,
    output logic                     access_bank,
    // Interrupt events
    input  wire logic                timer_overflow_event,
    input  wire logic                ext_pin_irq_event,
    input  wire logic                port_change_event,
    // Nonvolatile write control
    input  wire logic                nvm_write_start_set,
    input  wire logic                nvm_write_finished,
    input  wire logic                nvm_write_done_clear,
    output logic                     nvm_write_start,
    output logic                     nvm_write_done_flag,
    // Interrupt state
    output logic      [DATA_W-1:0]   interrupt_control,
    output logic                     irq_request
);

    logic [6:0]        offset;
    logic              hit_intctl;
    logic              hit_gpr;
    logic [DATA_W-1:0] ram_read;
    logic              ram_write;

    logic [DATA_W-1:0] next_read_data;
    logic              next_read_valid;
    logic              next_access_bank;
    logic [DATA_W-1:0] next_interrupt_control;
    logic              next_nvm_write_start;
    logic              next_nvm_write_done_flag;
    logic              next_irq_request;

    // Address decode
    always_comb begin
        offset     = access_indirect ? file_select_pointer[6:0] : direct_address;
        hit_intctl = (offset == OFFSET_INTCTL);
        hit_gpr    = is_gpr(offset);
        ram_write  = access_valid && access_write && hit_gpr;
    end

    general_ram u_general_ram (
        .clk_sys     (clk_sys),
        .write_en    (ram_write),
        .write_index (gpr_index(offset)),
        .write_data  (write_data),
        .read_index  (gpr_index(offset)),
        .read_data   (ram_read)
    );

    // Read path and bank report
    always_comb begin
        next_read_data   = read_data;
        next_read_valid  = access_valid && !access_write;
        next_access_bank = access_bank;
        if (access_valid) begin
            next_access_bank = bank_page_bit;
        end
        if (access_valid && !access_write) begin
            if (hit_intctl) begin
                next_read_data = interrupt_control;
            end else if (hit_gpr) begin
                next_read_data = ram_read;
            end else begin
                next_read_data = '0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            read_data   <= READ_DATA_RESET;
            read_valid  <= 1'b0;
            access_bank <= 1'b0;
        end else begin
            read_data   <= next_read_data;
            read_valid  <= next_read_valid;
            access_bank <= next_access_bank;
        end
    end

    // Interrupt control, flags and request
    always_comb begin
        next_interrupt_control   = interrupt_control;
        next_nvm_write_start     = nvm_write_start;
        next_nvm_write_done_flag = nvm_write_done_flag;
        if (access_valid && access_write && hit_intctl) begin
            next_interrupt_control = write_data;
        end
        // Hardware set wins over a software clear in the same cycle
        if (timer_overflow_event) begin
            next_interrupt_control[BIT_TIMER_FLAG] = 1'b1;
        end
        if (ext_pin_irq_event) begin
            next_interrupt_control[BIT_EXT_FLAG] = 1'b1;
        end
        if (port_change_event) begin
            next_interrupt_control[BIT_PORT_FLAG] = 1'b1;
        end
        if (nvm_write_start_set) begin
            next_nvm_write_start = 1'b1;
        end
        if (nvm_write_done_clear) begin
            next_nvm_write_done_flag = 1'b0;
        end
        if (nvm_write_finished) begin
            next_nvm_write_start     = 1'b0;
            next_nvm_write_done_flag = 1'b1;
        end
        next_irq_request = next_interrupt_control[BIT_GLOBAL_EN] && (
              (next_interrupt_control[BIT_NVM_EN]   && next_nvm_write_done_flag)
            | (next_interrupt_control[BIT_TIMER_EN] && next_interrupt_control[BIT_TIMER_FLAG])
            | (next_interrupt_control[BIT_EXT_EN]   && next_interrupt_control[BIT_EXT_FLAG])
            | (next_interrupt_control[BIT_PORT_EN]  && next_interrupt_control[BIT_PORT_FLAG]));
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_control   <= INTCTL_RESET;
            nvm_write_start     <= 1'b0;
            nvm_write_done_flag <= 1'b0;
            irq_request         <= 1'b0;
        end else begin
            interrupt_control   <= next_interrupt_control;
            nvm_write_start     <= next_nvm_write_start;
            nvm_write_done_flag <= next_nvm_write_done_flag;
            irq_request         <= next_irq_request;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_irq_needs_global;
        irq_request |-> interrupt_control[BIT_GLOBAL_EN];
    endproperty
    a_irq_needs_global: assert property (p_irq_needs_global) else $error("request without global enable");

    property p_irq_needs_source;
        irq_request |-> ((interrupt_control[6] && nvm_write_done_flag) || |(interrupt_control[5:3] & interrupt_control[2:0]));
    endproperty
    a_irq_needs_source: assert property (p_irq_needs_source) else $error("request without enabled flagged source");

    property p_timer_flag_set;
        timer_overflow_event |=> interrupt_control[BIT_TIMER_FLAG];
    endproperty
    a_timer_flag_set: assert property (p_timer_flag_set) else $error("timer flag not set");

    property p_flags_sticky;
        (interrupt_control[2:0] != 3'h0) && !(access_valid && access_write && hit_intctl)
            |=> ((interrupt_control[2:0] & $past(interrupt_control[2:0])) == $past(interrupt_control[2:0]));
    endproperty
    a_flags_sticky: assert property (p_flags_sticky) else $error("flag dropped without software write");

    property p_nvm_done;
        nvm_write_finished |=> (nvm_write_done_flag && !nvm_write_start);
    endproperty
    a_nvm_done: assert property (p_nvm_done) else $error("write completion not handled");

    property p_nvm_flag_holds;
        nvm_write_done_flag && !nvm_write_done_clear |=> nvm_write_done_flag;
    endproperty
    a_nvm_flag_holds: assert property (p_nvm_flag_holds) else $error("done flag lost");

    property p_intctl_write;
        access_valid && access_write && hit_intctl && !timer_overflow_event && !ext_pin_irq_event
            && !port_change_event |=> interrupt_control == $past(write_data);
    endproperty
    a_intctl_write: assert property (p_intctl_write) else $error("control write not stored");

    property p_intctl_read;
        access_valid && !access_write && hit_intctl |=> read_valid && read_data == $past(interrupt_control);
    endproperty
    a_intctl_read: assert property (p_intctl_read) else $error("control read wrong");

    property p_sfr_gap_zero;
        access_valid && !access_write && !hit_gpr && !hit_intctl |=> read_data == 8'h00;
    endproperty
    a_sfr_gap_zero: assert property (p_sfr_gap_zero) else $error("unmapped location not zero");

    property p_gpr_alias;
        access_valid && access_write && hit_gpr ##1 access_valid && !access_write && hit_gpr
            && offset == $past(offset) |=> read_data == $past(write_data, 2);
    endproperty
    a_gpr_alias: assert property (p_gpr_alias) else $error("general RAM readback wrong");

    c_irq_raised: cover property (!irq_request ##1 irq_request);
    c_alias_write: cover property (access_valid && access_write && hit_intctl && bank_page_bit);
    c_indirect_gpr: cover property (access_valid && access_indirect && hit_gpr && !access_write);
    c_nvm_finish: cover property (nvm_write_start ##1 nvm_write_finished);

endmodule // banked_register_file_intctl
`default_nettype wire

// ### tb/core_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_model
    import regfile_pkg::*;
(
    // Clock
    input  wire logic              clk_sys,
    // Access request
    output logic                   access_valid,
    output logic                   access_write,
    output logic                   access_indirect,
    output logic [6:0]             direct_address,
    output logic [7:0]             file_select_pointer,
    output logic                   bank_page_bit,
    output logic [DATA_W-1:0]      write_data,
    // Answer
    input  wire logic [DATA_W-1:0] read_data,
    input  wire logic              read_valid
);
    initial begin
        access_valid        = 1'b0;
        access_write        = 1'b0;
        access_indirect     = 1'b0;
        direct_address      = 7'h00;
        file_select_pointer = 8'h00;
        bank_page_bit       = 1'b0;
        write_data          = 8'h00;
    end

    // One access; the unused address source carries a wrong offset
    task automatic access(input logic wr, input logic ind, input logic [6:0] off, input logic bank,
                          input logic [7:0] dat, output logic [7:0] rd, output logic ok);
        @(negedge clk_sys);
        access_valid        = 1'b1;
        access_write        = wr;
        access_indirect     = ind;
        direct_address      = ind ? ~off : off;
        file_select_pointer = {wr, ind ? off : ~off};
        bank_page_bit       = bank;
        write_data          = wr ? dat : ~dat;
        @(negedge clk_sys);
        ok                  = read_valid;
        rd                  = read_data;
        access_valid        = 1'b0;
        direct_address      = ~direct_address;
        file_select_pointer = ~file_select_pointer;
        write_data          = ~write_data;
    endtask

    // Write directly, then read back indirectly from the other bank on the very next cycle
    task automatic write_read(input logic [6:0] off, input logic [7:0] dat, output logic [7:0] rd, output logic ok);
        @(negedge clk_sys);
        access_valid        = 1'b1;
        access_write        = 1'b1;
        access_indirect     = 1'b0;
        direct_address      = off;
        file_select_pointer = {1'b0, ~off};
        bank_page_bit       = 1'b0;
        write_data          = dat;
        @(negedge clk_sys);
        access_write        = 1'b0;
        access_indirect     = 1'b1;
        direct_address      = ~off;
        file_select_pointer = {1'b1, off};
        bank_page_bit       = 1'b1;
        write_data          = ~dat;
        @(negedge clk_sys);
        ok                  = read_valid;
        rd                  = read_data;
        access_valid        = 1'b0;
    endtask
endmodule // core_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import regfile_pkg::*;
    logic       clk_sys, rst_n, access_valid, access_write, access_indirect, bank_page_bit;
    logic [6:0] direct_address, off;
    logic [7:0] file_select_pointer, write_data, read_data, interrupt_control, ectl, d;
    logic       read_valid, access_bank, nvm_write_start, nvm_write_done_flag, irq_request, b, ind;
    logic [2:0] ev;
    logic       nvm_s, nvm_f, nvm_c;
    int         error_cnt, compares;

    core_model u_core_model (.clk_sys(clk_sys), .access_valid(access_valid), .access_write(access_write),
        .access_indirect(access_indirect), .direct_address(direct_address), .file_select_pointer(file_select_pointer),
        .bank_page_bit(bank_page_bit), .write_data(write_data), .read_data(read_data), .read_valid(read_valid));
    banked_register_file_intctl u_banked_register_file_intctl (.clk_sys(clk_sys), .rst_n(rst_n),
        .access_valid(access_valid), .access_write(access_write), .access_indirect(access_indirect),
        .direct_address(direct_address), .file_select_pointer(file_select_pointer), .bank_page_bit(bank_page_bit),
        .write_data(write_data), .read_data(read_data), .read_valid(read_valid), .access_bank(access_bank),
        .timer_overflow_event(ev[2]), .ext_pin_irq_event(ev[1]), .port_change_event(ev[0]),
        .nvm_write_start_set(nvm_s), .nvm_write_finished(nvm_f), .nvm_write_done_clear(nvm_c),
        .nvm_write_start(nvm_write_start), .nvm_write_done_flag(nvm_write_done_flag),
        .interrupt_control(interrupt_control), .irq_request(irq_request));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask
    function automatic logic irq_exp(input logic [7:0] c, input logic nf);
        return c[7] & ((|(c[5:3] & c[2:0])) | (c[6] & nf));
    endfunction
    task automatic rw(input logic wr, input logic i, input logic [6:0] o, input logic bk,
                      input logic [7:0] dat, input logic [7:0] exp);
        logic [7:0] rd;
        logic       ok;
        u_core_model.access(wr, i, o, bk, dat, rd, ok);
        chk_bit("read_valid", !wr, ok);
        chk_bit("access_bank", bk, access_bank);
        if (!wr) chk_byte("read_data", exp, rd);
    endtask
    task automatic wr_rd(input logic [6:0] o, input logic [7:0] dat);
        logic [7:0] rd;
        logic       ok;
        u_core_model.write_read(o, dat, rd, ok);
        chk_bit("read_valid", 1'b1, ok);
        chk_byte("read_data", dat, rd);
    endtask
    task automatic chk_ctl(input logic nf);
        chk_byte("interrupt_control", ectl, interrupt_control);
        chk_bit("irq_request", irq_exp(ectl, nf), irq_request);
    endtask
    task automatic pulse(input logic [2:0] e, input logic s, input logic f, input logic c);
        @(negedge clk_sys);
        {ev, nvm_s, nvm_f, nvm_c} = {e, s, f, c};
        @(negedge clk_sys);
        {ev, nvm_s, nvm_f, nvm_c} = 6'h00;
        ectl = ectl | {5'h00, e};
    endtask
    task automatic wctl(input logic [7:0] v, input logic nf);
        rw(1'b1, v[0], OFFSET_INTCTL, v[1], v, 8'h00);
        ectl = v;
        chk_ctl(nf);
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        error_cnt++;
        complete_run();
    end

    initial begin
        void'($urandom(23));
        {rst_n, ev, nvm_s, nvm_f, nvm_c, ectl} = 15'h0000;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        chk_ctl(1'b0);
        rw(1'b1, 1'b0, 7'h0c, 1'b0, 8'h5a, 8'h00);
        rw(1'b0, 1'b0, 7'h0c, 1'b1, 8'h00, 8'h5a);
        rw(1'b1, 1'b1, 7'h7f, 1'b1, 8'ha5, 8'h00);
        rw(1'b0, 1'b0, 7'h7f, 1'b0, 8'h00, 8'ha5);
        for (int i = 0; i < 40; i++) begin
            off = 7'($urandom_range(127, 12));
            d   = 8'($urandom);
            {b, ind} = 2'($urandom);
            rw(1'b1, ind, off, b, d, 8'h00);
            rw(1'b0, !ind, off, !b, 8'h00, d);
            wr_rd(off, ~d);
        end
        for (int i = 0; i < 11; i++) begin
            rw(1'b1, i[0], 7'(i), i[1], 8'hff, 8'h00);
            rw(1'b0, i[1], 7'(i), i[0], 8'h00, 8'h00);
        end
        wctl(8'h7f, 1'b0);
        wctl(8'hff, 1'b0);
        for (int i = 0; i < 3; i++) begin
            wctl(8'h80 | (8'h20 >> i), 1'b0);
            pulse(3'h4 >> i, 1'b0, 1'b0, 1'b0);
            chk_ctl(1'b0);
        end
        for (int i = 0; i < 30; i++) begin
            wctl(8'($urandom), 1'b0);
            rw(1'b0, ind, OFFSET_INTCTL, !interrupt_control[1], 8'h00, ectl);
            pulse(3'($urandom), 1'b0, 1'b0, 1'b0);
            chk_ctl(1'b0);
        end
        // Software clear and timer event in one cycle: the event must win
        fork
            rw(1'b1, 1'b0, OFFSET_INTCTL, 1'b1, 8'ha0, 8'h00);
            pulse(3'h4, 1'b0, 1'b0, 1'b0);
        join
        ectl = 8'ha4;
        chk_ctl(1'b0);
        wctl(8'hc0, 1'b0);
        pulse(3'h0, 1'b1, 1'b0, 1'b0);
        chk_bit("nvm_write_start", 1'b1, nvm_write_start);
        pulse(3'h0, 1'b0, 1'b1, 1'b1);
        chk_bit("nvm_write_start", 1'b0, nvm_write_start);
        chk_bit("nvm_write_done_flag", 1'b1, nvm_write_done_flag);
        chk_ctl(1'b1);
        wctl(8'h80, 1'b1);
        pulse(3'h0, 1'b0, 1'b0, 1'b1);
        chk_bit("nvm_write_done_flag", 1'b0, nvm_write_done_flag);
        pulse(3'h0, 1'b1, 1'b1, 1'b0);
        chk_bit("nvm_write_start", 1'b0, nvm_write_start);
        chk_bit("nvm_write_done_flag", 1'b1, nvm_write_done_flag);
        // Reset in mid-run clears control, flags and request
        @(negedge clk_sys);
        rst_n = 1'b0;
        @(negedge clk_sys);
        ectl = INTCTL_RESET;
        chk_ctl(1'b0);
        chk_bit("nvm_write_done_flag", 1'b0, nvm_write_done_flag);
        chk_bit("read_valid", 1'b0, read_valid);
        rst_n = 1'b1;
        rw(1'b0, 1'b1, OFFSET_INTCTL, 1'b1, 8'h00, INTCTL_RESET);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
